// [hdl/tap_consts.svh]
// Constants for the test access and debug port
`ifndef TAP_CONSTS_SVH
`define TAP_CONSTS_SVH
`define IR_W           4
`define IR_RESET       4'h1
`define IR_DEVICE_IDENTITY_WORD      4'h1
`define IR_USERCODE    4'h2
`define IR_SAMPLE      4'h3
`define IR_EXTEST      4'h0
`define IR_DEBUG       4'h8
`define IR_BYPASS      4'hF
`define CHIP_DR_W      32
`define UID_LSB        22
`define UID_MSB        31
`define SEC_JTAG_DIS   1
`define SEC_DEBUG_DIS  2
`define SEC_OTP_BOOT   5
`define VERSION_RST    4'h0
`define PART_RST       16'h0000
`define MFR_RST        11'h000
`define SILICON_REV    16'h0000
`define BOOT_MODE_MSB  3
`define BOOT_MODE_LSB  2
`define BOOT_OTP       2'h3
`endif

// [hdl/tap_pkg.sv]
// Types for the test access and debug port
package tap_pkg;
  typedef enum logic [3:0] {
    TLR = 4'h0, RTI = 4'h1, SEL_DR = 4'h2, CAP_DR = 4'h3,
    SH_DR = 4'h4, EX1_DR = 4'h5, PA_DR = 4'h6, EX2_DR = 4'h7,
    UPD_DR = 4'h8, SEL_IR = 4'h9, CAP_IR = 4'hA, SH_IR = 4'hB,
    EX1_IR = 4'hC, PA_IR = 4'hD, EX2_IR = 4'hE, UPD_IR = 4'hF
  } tap_state_e;
  typedef enum logic [1:0] {
    B_RESET = 2'h0, B_WAIT_LOCK = 2'h1, B_BOOT = 2'h2, B_RUN = 2'h3
  } boot_state_e;
endpackage

// [hdl/test_access_debug_port.sv]
// Two-controller scan chain, debug sync pin and boot sequencing
// Notes on behaviour
// - After reset chain holds exactly two controllers
// - Boundary controller follows standard, scans pins
// - Chip controller reaches tile, switch, OTP memory
// - Sync pin output: float until breakpoint, low
// - Sync pin input: low enters debug mode
// - Software selects tile response to sync pin
// - Identity: version, part, maker, bit0 one
// - User code: user id bits 22-31, revision
// - User id zero when memory unprogrammed
// - System reset active low, synchronised, asserts synchronously
// - After release wait lock, then boot
// - Boot source from two upper select pins, or OTP when its security bit is set
// - Security bit disables test access to tile
// - Test operations follow test clock only
`include "tap_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module test_access_debug_port #(
  parameter int         NPINS   = 8,
  parameter logic [3:0] VERSION = `VERSION_RST, // Arbitrary value
  parameter logic [15:0] PART   = `PART_RST,    // Arbitrary value
  parameter logic [10:0] MFR    = `MFR_RST      // Arbitrary value
) (
  input  wire logic             CLK,
  input  wire logic             RST,
  input  wire logic             CE,
  input  wire logic             TCK,
  input  wire logic             TMS,
  input  wire logic             TDI,
  input  wire logic             TRST_LOW,
  output logic                  TDO,
  output logic                  TDO_OE,
  input  wire logic [NPINS-1:0] PIN_IN,
  output logic      [NPINS-1:0] PIN_OUT,
  output logic                  PIN_OVERRIDE,
  input  wire logic [31:0]      SECURITY,
  input  wire logic             OTP_PROGRAMMED,
  input  wire logic             BREAKPOINT,
  input  wire logic             SYNC_OUT_EN,
  input  wire logic             SYNC_IN_EN,
  input  wire logic             SYNC_IN,
  output logic                  SYNC_OUT,
  output logic                  SYNC_OE,
  output logic                  DEBUG_MODE,
  output logic                  CHIP_UPDATE,
  output logic [31:0]           CHIP_DATA,
  output logic [3:0]            CHIP_IR,
  input  wire logic [31:0]      CHIP_READ,
  input  wire logic             SYS_RST_LOW,
  input  wire logic             PLL_LOCK,
  input  wire logic [3:0]       BOOT_MODE,
  output logic                  BOOT_START,
  output logic [1:0]            BOOT_SOURCE,
  output logic                  CORE_RESET
);
  // Pin synchronisers; first stage feeds only the second
  logic [7:0] s1_q, s2_q;
  logic       tck_prev_q;
  always_ff @(posedge CLK)
  begin
    if (CE)
    begin
      s1_q <= {SYS_RST_LOW, PLL_LOCK, SYNC_IN, TRST_LOW, TDI, TMS, TCK,
               1'b0};
      s2_q <= s1_q;
    end
  end
  logic tck_s, tms_s, tdi_s, trst_s, syncin_s, lock_s, srst_s;
  assign {srst_s, lock_s, syncin_s, trst_s, tdi_s, tms_s, tck_s} = s2_q[7:1];
  wire tck_rise = tck_s & ~tck_prev_q;
  wire tck_fall = ~tck_s & tck_prev_q;
  wire jtag_off = SECURITY[`SEC_JTAG_DIS];
  wire trst     = ~trst_s | RST;

  // TAP state, two instruction and data registers, both in series
  tap_pkg::tap_state_e st_q, st_d;
  logic [`IR_W-1:0] bir_q, bir_d, cir_q, cir_d, bish_q, bish_d;
  logic [`IR_W-1:0] cish_q, cish_d;
  logic [NPINS-1:0] bsr_q, bsr_d, bupd_q, bupd_d;
  logic [31:0] cdr_q, cdr_d, cupd_q, cupd_d;
  logic        bbyp_q, bbyp_d, tdo_q, tdo_d, oe_q, oe_d;
  logic        upd_pulse_d, upd_pulse_q;
  logic [31:0] idword, ucword, cap;
  // Identity word layout, bit0 fixed one
  assign idword = {VERSION, PART, MFR, 1'b1};
  // User id zero on blank memory
  assign ucword = {OTP_PROGRAMMED ? SECURITY[`UID_MSB:`UID_LSB] : 10'h000,
                   6'h00, `SILICON_REV};
  always_comb
  begin
    unique case (cir_q)
      `IR_DEVICE_IDENTITY_WORD:   cap = idword;
      `IR_USERCODE: cap = ucword;
      `IR_DEBUG:    cap = jtag_off ? 32'h00000000 : CHIP_READ;
      default:      cap = 32'h00000000;
    endcase
  end
  // Chain order: TDI -> chip controller -> boundary controller -> TDO
  wire bnd_dr_byp = (bir_q == `IR_BYPASS) || (bir_q == `IR_DEVICE_IDENTITY_WORD);
  wire chip_len_byp = (cir_q == `IR_BYPASS);
  always_comb
  begin
    st_d = st_q; bir_d = bir_q; cir_d = cir_q; bish_d = bish_q;
    cish_d = cish_q; bsr_d = bsr_q; bupd_d = bupd_q; cdr_d = cdr_q;
    cupd_d = cupd_q; bbyp_d = bbyp_q; tdo_d = tdo_q; oe_d = oe_q;
    upd_pulse_d = 1'b0;
    if (tck_rise)
    begin
      unique case (st_q)
        tap_pkg::TLR:    st_d = tms_s ? tap_pkg::TLR : tap_pkg::RTI;
        tap_pkg::RTI:    st_d = tms_s ? tap_pkg::SEL_DR : tap_pkg::RTI;
        tap_pkg::SEL_DR: st_d = tms_s ? tap_pkg::SEL_IR : tap_pkg::CAP_DR;
        tap_pkg::CAP_DR: st_d = tms_s ? tap_pkg::EX1_DR : tap_pkg::SH_DR;
        tap_pkg::SH_DR:  st_d = tms_s ? tap_pkg::EX1_DR : tap_pkg::SH_DR;
        tap_pkg::EX1_DR: st_d = tms_s ? tap_pkg::UPD_DR : tap_pkg::PA_DR;
        tap_pkg::PA_DR:  st_d = tms_s ? tap_pkg::EX2_DR : tap_pkg::PA_DR;
        tap_pkg::EX2_DR: st_d = tms_s ? tap_pkg::UPD_DR : tap_pkg::SH_DR;
        tap_pkg::UPD_DR: st_d = tms_s ? tap_pkg::SEL_DR : tap_pkg::RTI;
        tap_pkg::SEL_IR: st_d = tms_s ? tap_pkg::TLR : tap_pkg::CAP_IR;
        tap_pkg::CAP_IR: st_d = tms_s ? tap_pkg::EX1_IR : tap_pkg::SH_IR;
        tap_pkg::SH_IR:  st_d = tms_s ? tap_pkg::EX1_IR : tap_pkg::SH_IR;
        tap_pkg::EX1_IR: st_d = tms_s ? tap_pkg::UPD_IR : tap_pkg::PA_IR;
        tap_pkg::PA_IR:  st_d = tms_s ? tap_pkg::EX2_IR : tap_pkg::PA_IR;
        tap_pkg::EX2_IR: st_d = tms_s ? tap_pkg::UPD_IR : tap_pkg::SH_IR;
        tap_pkg::UPD_IR: st_d = tms_s ? tap_pkg::SEL_DR : tap_pkg::RTI;
      endcase
      unique case (st_q)
        tap_pkg::CAP_IR:
        begin
          bish_d = 4'h1;
          cish_d = 4'h1;
        end
        tap_pkg::SH_IR:
        begin
          cish_d = {tdi_s, cish_q[`IR_W-1:1]};
          bish_d = {cish_q[0], bish_q[`IR_W-1:1]};
        end
        tap_pkg::CAP_DR:
        begin
          bsr_d = PIN_IN;
          bbyp_d = 1'b0;
          cdr_d = cap;
        end
        tap_pkg::SH_DR:
        begin
          if (chip_len_byp)
            cdr_d[0] = tdi_s;
          else
            cdr_d = {tdi_s, cdr_q[31:1]};
          if (bnd_dr_byp)
            bbyp_d = cdr_q[0];
          else
            bsr_d = {cdr_q[0], bsr_q[NPINS-1:1]};
        end
        default:
        begin
        end
      endcase
    end
    if (tck_fall)
    begin
      // Output changes on falling edge, as the probe samples on rising
      oe_d = (st_q == tap_pkg::SH_DR) || (st_q == tap_pkg::SH_IR);
      unique case (st_q)
        tap_pkg::SH_IR: tdo_d = bish_q[0];
        tap_pkg::SH_DR: tdo_d = bnd_dr_byp ? bbyp_q : bsr_q[0];
        default: tdo_d = tdo_q;
      endcase
      if (st_q == tap_pkg::UPD_IR)
      begin
        bir_d = bish_q;
        cir_d = jtag_off ? `IR_BYPASS : cish_q;
      end
      if (st_q == tap_pkg::UPD_DR)
      begin
        if (bir_q == `IR_EXTEST)
          bupd_d = bsr_q;
        if (cir_q == `IR_DEBUG && !jtag_off)
        begin
          cupd_d = cdr_q;
          upd_pulse_d = 1'b1;
        end
      end
      if (st_q == tap_pkg::TLR)
      begin
        bir_d = `IR_RESET;
        cir_d = `IR_RESET;
      end
    end
  end
  always_ff @(posedge CLK)
  begin
    if (RST)
      tck_prev_q <= 1'b0;
    else if (CE)
      tck_prev_q <= tck_s;
  end
  always_ff @(posedge CLK)
  begin
    if (trst)
    begin
      st_q <= tap_pkg::TLR;
      bir_q <= `IR_RESET;
      cir_q <= `IR_RESET;
      bish_q <= 4'h0; cish_q <= 4'h0;
      bsr_q <= '0; bupd_q <= '0;
      cdr_q <= 32'h00000000; cupd_q <= 32'h00000000;
      bbyp_q <= 1'b0; tdo_q <= 1'b0; oe_q <= 1'b0;
      upd_pulse_q <= 1'b0;
    end
    else if (CE)
    begin
      st_q <= st_d; bir_q <= bir_d; cir_q <= cir_d;
      bish_q <= bish_d; cish_q <= cish_d;
      bsr_q <= bsr_d; bupd_q <= bupd_d;
      cdr_q <= cdr_d; cupd_q <= cupd_d;
      bbyp_q <= bbyp_d; tdo_q <= tdo_d; oe_q <= oe_d;
      upd_pulse_q <= upd_pulse_d;
    end
  end
  assign TDO = tdo_q;
  assign TDO_OE = oe_q;
  assign PIN_OUT = bupd_q;
  assign PIN_OVERRIDE = (bir_q == `IR_EXTEST);
  assign CHIP_DATA = cupd_q;
  assign CHIP_IR = cir_q;
  assign CHIP_UPDATE = upd_pulse_q;

  // Debug sync pin; software enables pick the response
  logic dbg_q, dbg_d, sync_oe_q, sync_oe_d;
  wire  sync_ok = ~SECURITY[`SEC_DEBUG_DIS];
  always_comb
  begin
    dbg_d = dbg_q;
    sync_oe_d = sync_oe_q;
    if (SYNC_IN_EN && sync_ok && !syncin_s)
      dbg_d = 1'b1;
    if (BREAKPOINT)
      dbg_d = 1'b1;
    // Stays driven low until reset or SYNC_OUT_EN drops; release is a system decision
    if (SYNC_OUT_EN && sync_ok && BREAKPOINT)
      sync_oe_d = 1'b1;
    if (!SYNC_OUT_EN)
      sync_oe_d = 1'b0;
  end
  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      dbg_q <= 1'b0;
      sync_oe_q <= 1'b0;
    end
    else if (CE)
    begin
      dbg_q <= dbg_d;
      sync_oe_q <= sync_oe_d;
    end
  end
  assign SYNC_OUT = 1'b0;
  assign SYNC_OE = sync_oe_q;
  assign DEBUG_MODE = dbg_q;

  // Boot sequencing; reset pin is synchronised, so its assertion
  // reaches the core reset two cycles late but independent of state
  tap_pkg::boot_state_e bs_q, bs_d;
  logic [1:0] src_q, src_d;
  always_comb
  begin
    bs_d = bs_q;
    src_d = src_q;
    unique case (bs_q)
      tap_pkg::B_RESET:     bs_d = tap_pkg::B_WAIT_LOCK;
      tap_pkg::B_WAIT_LOCK: if (lock_s) bs_d = tap_pkg::B_BOOT;
      tap_pkg::B_BOOT:
      begin
        src_d = SECURITY[`SEC_OTP_BOOT] ? `BOOT_OTP
              : BOOT_MODE[`BOOT_MODE_MSB:`BOOT_MODE_LSB];
        bs_d = tap_pkg::B_RUN;
      end
      tap_pkg::B_RUN:       bs_d = tap_pkg::B_RUN;
    endcase
  end
  always_ff @(posedge CLK)
  begin
    if (RST || !srst_s)
    begin
      bs_q <= tap_pkg::B_RESET;
      src_q <= 2'h0;
    end
    else if (CE)
    begin
      bs_q <= bs_d;
      src_q <= src_d;
    end
  end
  assign BOOT_START = (bs_q == tap_pkg::B_BOOT);
  assign BOOT_SOURCE = src_q;
  assign CORE_RESET = (bs_q != tap_pkg::B_RUN) && (bs_q != tap_pkg::B_BOOT);
endmodule
`default_nettype wire

// [verification/scan_probe.sv]
// Behavioural scan probe on the test port pins
`timescale 1ns/1ps
`default_nettype none
module scan_probe (
  input  wire logic clk,
  input  wire logic tdo,
  output var logic  tck,
  output var logic  tms,
  output var logic  tdi,
  output var logic  trst_low
);
  // Test reset low from power-up until released
  initial
  begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b1;
    trst_low = 1'b0;
  end
  task hold_reset(input logic v);
    trst_low <= !v;
  endtask
  // One test clock; slow phases so the synchroniser sees it
  task tick(input logic m, input logic d, output logic q);
    tms <= m;
    tdi <= d;
    repeat (8) @(posedge clk);
    q = tdo;
    tck <= 1'b1;
    repeat (8) @(posedge clk);
    tck <= 1'b0;
  endtask
  // Five ones reach logic reset whatever the state
  task park();
    logic q;
    repeat (5) tick(1'b1, 1'b1, q);
    tick(1'b0, 1'b1, q);
  endtask
  // Idle to shift, n bits LSB first, back to idle
  task scan(input logic ir, input int n, input logic [39:0] d,
            output logic [39:0] q);
    logic b;
    q = '0;
    tick(1'b1, 1'b1, b);
    if (ir)
      tick(1'b1, 1'b1, b);
    tick(1'b0, 1'b1, b);
    tick(1'b0, 1'b1, b);
    for (int i = 0; i < n; i++)
    begin
      tick(i == n - 1, d[i], b);
      q[i] = b;
    end
    tick(1'b1, 1'b1, b);
    tick(1'b0, 1'b1, b);
  endtask
endmodule
`default_nettype wire

// [verification/tap_checker.sv]
// Assertions on the test port, debug pin and boot pins
`timescale 1ns/1ps
`default_nettype none
module tap_checker (
  input wire logic        CLK,
  input wire logic        RST,
  input wire logic        TCK,
  input wire logic        TRST_LOW,
  input wire logic        TDO,
  input wire logic        TDO_OE,
  input wire logic [31:0] SECURITY,
  input wire logic        BREAKPOINT,
  input wire logic        SYNC_OUT_EN,
  input wire logic        SYNC_IN_EN,
  input wire logic        SYNC_IN,
  input wire logic        SYNC_OE,
  input wire logic        DEBUG_MODE,
  input wire logic        PLL_LOCK,
  input wire logic [3:0]  BOOT_MODE,
  input wire logic        BOOT_START,
  input wire logic [1:0]  BOOT_SOURCE
);
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);
  // Held test reset keeps the scan output off
  a_trst_quiet: assert property (!TRST_LOW [*6] |-> !TDO_OE)
    else $error("scan output on in test reset");
  // Output moves only in the low test clock phase
  a_tdo_edge: assert property ($changed(TDO) && TRST_LOW
    |-> !TCK && !$past(TCK))
    else $error("scan output moved off falling edge");
  // Sync pin floats unless output mode is chosen
  a_sync_float: assert property (!SYNC_OUT_EN [*3] |-> !SYNC_OE)
    else $error("sync pin driven while not selected");
  a_sync_drive: assert property (
    (SYNC_OUT_EN && BREAKPOINT && !SECURITY[2]) [*4] |-> SYNC_OE)
    else $error("sync pin not driven at breakpoint");
  // Low input level enters debug, which then sticks
  a_debug_entry: assert property (
    (SYNC_IN_EN && !SYNC_IN && !SECURITY[2]) [*5] |-> DEBUG_MODE)
    else $error("debug mode not entered");
  a_debug_hold: assert property (DEBUG_MODE |=> DEBUG_MODE)
    else $error("debug mode dropped");
  // Boot waits for lock, fires once, uses select pins or OTP when its security bit is set
  a_boot_lock: assert property (BOOT_START |-> $past(PLL_LOCK, 2))
    else $error("boot before lock");
  a_boot_once: assert property (BOOT_START |=> !BOOT_START)
    else $error("boot start longer than a cycle");
  a_boot_src: assert property (BOOT_START |-> ##[0:2]
    BOOT_SOURCE == (SECURITY[5] ? 2'h3 : BOOT_MODE[3:2]))
    else $error("wrong boot source");
  c_boot: cover property (BOOT_START);
  c_debug: cover property ($rose(DEBUG_MODE));
  c_sync: cover property ($rose(SYNC_OE));
endmodule
bind test_access_debug_port tap_checker i_chk (.CLK, .RST, .TCK, .TRST_LOW,
  .TDO, .TDO_OE, .SECURITY, .BREAKPOINT, .SYNC_OUT_EN, .SYNC_IN_EN,
  .SYNC_IN, .SYNC_OE, .DEBUG_MODE, .PLL_LOCK, .BOOT_MODE, .BOOT_START,
  .BOOT_SOURCE);
`default_nettype wire

// [verification/tb.sv]
// Self-checking bench for the test access and debug port
`include "tap_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic        CLK = 1'b0;
  logic        RST = 1'b1;
  logic        TCK, TMS, TDI, TRST_LOW, TDO, TDO_OE, PIN_OVERRIDE;
  logic [31:0] SECURITY = 32'hA940_0000;
  logic        OTP_PROGRAMMED = 1'b0;
  logic        BREAKPOINT = 1'b0;
  logic        SYNC_OUT_EN = 1'b0;
  logic        SYNC_IN_EN = 1'b0;
  logic        pin_low = 1'b0;
  logic        SYNC_OE, DEBUG_MODE, BOOT_START, b;
  logic        SYS_RST_LOW = 1'b0;
  logic        PLL_LOCK = 1'b0;
  logic [3:0]  BOOT_MODE = 4'h9;
  logic [1:0]  BOOT_SOURCE;
  logic [39:0] q;
  logic [7:0]  PIN_OUT;
  logic [31:0] CHIP_DATA;
  logic [3:0]  CHIP_IR;
  logic        CHIP_UPDATE, CORE_RESET;
  int          upd_cnt = 0;
  int          error_cnt = 0;
  int          checks = 0;
  int          n;
  // Pulled-up sync pin, low if either side drives it
  wire SYNC_IN = !(SYNC_OE || pin_low);
  always #5 CLK = ~CLK;
  // Identity fields are arbitrary values
  test_access_debug_port #(.VERSION(4'hA), .PART(16'h5A5A),
    .MFR(11'h123)) i_dut (.CLK, .RST, .CE(1'b1), .TCK, .TMS, .TDI,
    .TRST_LOW, .TDO, .TDO_OE, .PIN_IN(8'hA5), .PIN_OUT, .PIN_OVERRIDE,
    .SECURITY, .OTP_PROGRAMMED, .BREAKPOINT, .SYNC_OUT_EN, .SYNC_IN_EN,
    .SYNC_IN, .SYNC_OUT(), .SYNC_OE, .DEBUG_MODE, .CHIP_UPDATE,
    .CHIP_DATA, .CHIP_IR, .CHIP_READ(32'hC3C3_5A5A), .SYS_RST_LOW,
    .PLL_LOCK, .BOOT_MODE, .BOOT_START, .BOOT_SOURCE, .CORE_RESET);
  // Count tile update strobes; each lasts one clock only
  always @(posedge CLK)
    if (!RST)
      upd_cnt <= upd_cnt + int'(CHIP_UPDATE);
  scan_probe i_probe (.clk(CLK), .tdo(TDO), .tck(TCK), .tms(TMS),
    .tdi(TDI), .trst_low(TRST_LOW));
  task chk(input string nm, input logic [39:0] e, input logic [39:0] g);
    checks++;
    if (g !== e)
    begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task ir(input logic [7:0] v);
    i_probe.scan(1'b1, 8, {32'h0, v}, q);
  endtask
  task dr(input int len, input logic [39:0] d);
    i_probe.scan(1'b0, len, d, q);
  endtask
  task settle();
    repeat (10) @(posedge CLK);
  endtask
  task end_of_test();
    if (error_cnt == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // Bound about four times the expected run length
  initial
  begin
    #200000;
    error_cnt++;
    end_of_test();
  end
  initial
  begin
    repeat (20) @(posedge CLK);
    RST <= 1'b0;
    i_probe.hold_reset(1'b0);
    i_probe.park();
    ir(8'h11);
    chk("ir capture", 40'h5, {q[5:4], q[1:0]});
    dr(33, 40'h0);
    chk("identity", {7'h0, 4'hA, 16'h5A5A, 11'h123, 2'b10}, q);
    // User id shows only on programmed parts
    for (int k = 0; k < 2; k++)
    begin
      OTP_PROGRAMMED <= k[0];
      ir(8'h2F);
      dr(33, 40'h0);
      chk("usercode", {7'h0, k ? 10'h2A5 : 10'h0, 6'h0, `SILICON_REV,
          1'b0}, q);
    end
    SECURITY <= 32'hA940_0002;
    ir(8'h8F);
    chk("chip ir secure", 40'hF, CHIP_IR);
    dr(4, 40'h3);
    chk("secure bypass", 40'hC, q);
    chk("secure update", 40'h0, upd_cnt);
    // Debug access reads tile data and writes one word
    SECURITY <= 32'hA940_0000;
    ir(8'h8F);
    chk("chip ir", 40'h8, CHIP_IR);
    dr(33, {7'h0, 32'h1234_ABCD, 1'b0});
    chk("chip read", {7'h0, 32'hC3C3_5A5A, 1'b0}, q);
    chk("chip data", 40'h1234ABCD, CHIP_DATA);
    chk("chip update", 40'h1, upd_cnt);
    ir(8'hF0);
    chk("pin override", 40'h1, PIN_OVERRIDE);
    dr(9, 40'h13C);
    chk("pin capture", 40'h0A5, q);
    chk("pin drive", 40'h3C, PIN_OUT);
    // Test reset must drop the loaded instruction
    i_probe.hold_reset(1'b1);
    settle();
    chk("override in reset", 40'h0, PIN_OVERRIDE);
    i_probe.hold_reset(1'b0);
    settle();
    i_probe.tick(1'b0, 1'b1, b);
    dr(33, 40'h0);
    chk("identity again", {7'h0, 4'hA, 16'h5A5A, 11'h123, 2'b10}, q);
    pin_low <= 1'b1;
    settle();
    chk("debug off", 40'h0, DEBUG_MODE);
    SYNC_IN_EN <= 1'b1;
    settle();
    chk("debug on", 40'h1, DEBUG_MODE);
    pin_low <= 1'b0;
    SYNC_IN_EN <= 1'b0;
    SYNC_OUT_EN <= 1'b1;
    settle();
    chk("sync float", 40'h0, SYNC_OE);
    BREAKPOINT <= 1'b1;
    settle();
    chk("sync drive", 40'h1, SYNC_OE);
    // Boot from select pins, then forced by security bit
    for (int k = 0; k < 2; k++)
    begin
      SECURITY <= k ? 32'h20 : 32'h0;
      SYS_RST_LOW <= 1'b0;
      PLL_LOCK <= 1'b0;
      settle();
      chk("core reset", 40'h1, CORE_RESET);
      SYS_RST_LOW <= 1'b1;
      n = 0;
      // Look at the one-cycle start pulse away from its launching edge
      repeat (20) @(negedge CLK) n += BOOT_START;
      chk("boot before lock", 40'h0, n);
      chk("core held", 40'h1, CORE_RESET);
      @(posedge CLK);
      PLL_LOCK <= 1'b1;
      n = 0;
      while (!BOOT_START && n < 100)
      begin
        @(negedge CLK);
        n++;
      end
      chk("boot start", 40'h1, BOOT_START);
      repeat (3) @(posedge CLK);
      chk("boot source", k ? 2'h3 : 2'h2, BOOT_SOURCE);
      chk("core run", 40'h0, CORE_RESET);
    end
    end_of_test();
  end
endmodule
`default_nettype wire
